// [core/bdp_pkg.sv]
package bdp_pkg;
  localparam int PHASES = 2;
  localparam logic [7:0] ADDR_STATUS_A = 8'h0a;
  localparam logic [7:0] ADDR_STATUS_B = 8'h0b;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_CONFIG = 8'h11;
  // Field positions in status A.
  localparam int SA_TW = 0;
  localparam int SA_TSD = 1;
  localparam int SA_TEMP = 2;
  localparam int SA_SERR = 3;
  localparam int SA_POR = 4;
  localparam int SA_OV = 5;
  localparam int SA_RUN = 8;
  // Field positions in status B.
  localparam int SB_DUV = 0;
  localparam int SB_NOK = 1;
  localparam int SB_PIN = 8;
  // Field positions in control.
  localparam int CT_EN = 0;
  localparam int CT_AUTO = 4;
  localparam int CT_PINSEL = 5;
  localparam int CT_KEEP = 6;
  // Field positions in config.
  localparam int CF_TTHR = 0;
  localparam int CF_UVTHR = 4;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam int CLK_MHZ = 100;
  localparam int UV_BLANK_US = 150;
  localparam int INIT_US = 150;
  localparam int START_MAX_US = 500;
  localparam int UV_BLANK_CYC = UV_BLANK_US * CLK_MHZ;
  localparam int INIT_CYC = INIT_US * CLK_MHZ;
  localparam int START_MAX_CYC = START_MAX_US * CLK_MHZ;
  localparam int TMR_W = 16;
  typedef enum logic [1:0] {
    BDP_RESET = 2'b00,
    BDP_INIT = 2'b01,
    BDP_NORMAL = 2'b10,
    BDP_FAILSAFE = 2'b11
  } bdp_mode_t;
  typedef struct packed {
    logic over_warning;
    logic over_shutdown;
    logic [2:0] temp_code;
    logic serial_error;
    logic boost_overvoltage;
    logic boost_reactivated;
    logic divider_undervoltage;
    logic gate_supply_bad;
    logic [2:0] gate_supply_level;
    logic supply_ok;
    logic otp_failsafe_lock;
  } bdp_sense_t;
  typedef struct packed {
    bdp_mode_t mode;
    logic [TMR_W-1:0] timer;
    logic [TMR_W-1:0] blank;
    logic blank_done;
    logic [15:0] control;
    logic [15:0] config_reg;
    logic [5:0] flags_a;
    logic [1:0] flags_b;
    logic tsd_active;
    logic ov_active;
    logic [1:0] phase_on;
    logic [1:0] en_prev;
    logic [1:0] recover_armed;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_s3;
    logic [1:0] pin_level;
    logic [15:0] rdata;
    logic regulator_on;
  } bdp_state_t;
endpackage

// [core/bdp_core.sv]
`timescale 1ns/1ps
`default_nettype none
module bdp_core #(
  parameter int UV_BLANK = bdp_pkg::UV_BLANK_CYC,
  parameter int INIT_DELAY = bdp_pkg::INIT_CYC
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] wdata_in,
  input wire bdp_pkg::bdp_sense_t sense_in,
  input wire logic [1:0] enable_pin_in,
  output logic [15:0] rdata_out,
  output logic [1:0] gate_enable_out,
  output logic regulator_on_out,
  output bdp_pkg::bdp_mode_t mode_out
);
  bdp_pkg::bdp_state_t s;
  bdp_pkg::bdp_state_t next_s;
  logic [1:0] en_bits;
  logic auto_rec;
  logic pin_mode;
  logic any_pin;
  logic uv_lock;
  logic temp_hit;
  logic [1:0] en_rise;
  logic rd_a;
  logic rd_b;
  logic [5:0] ev_a;
  logic [1:0] ev_b;
  logic [15:0] stat_a;
  logic [15:0] stat_b;

  always_comb begin
    en_bits = s.control[bdp_pkg::CT_EN +: 2];
    pin_mode = s.control[bdp_pkg::CT_PINSEL];
    auto_rec = s.control[bdp_pkg::CT_AUTO] || (s.mode == bdp_pkg::BDP_FAILSAFE);
    any_pin = |s.pin_level;
    uv_lock = s.blank_done && (s.config_reg[bdp_pkg::CF_UVTHR +: 3] != 3'h0) &&
      (sense_in.gate_supply_level < s.config_reg[bdp_pkg::CF_UVTHR +: 3]);
    temp_hit = sense_in.temp_code > s.config_reg[bdp_pkg::CF_TTHR +: 3];
    en_rise = en_bits & ~s.en_prev;
    rd_a = rd_in && (addr_in == bdp_pkg::ADDR_STATUS_A);
    rd_b = rd_in && (addr_in == bdp_pkg::ADDR_STATUS_B);
    ev_a = '0;
    ev_a[bdp_pkg::SA_TW] = sense_in.over_warning;
    ev_a[bdp_pkg::SA_TSD] = sense_in.over_shutdown;
    ev_a[bdp_pkg::SA_TEMP] = temp_hit;
    ev_a[bdp_pkg::SA_SERR] = sense_in.serial_error;
    ev_a[bdp_pkg::SA_OV] = sense_in.boost_overvoltage;
    ev_b = '0;
    ev_b[bdp_pkg::SB_DUV] = sense_in.divider_undervoltage;
    ev_b[bdp_pkg::SB_NOK] = sense_in.gate_supply_bad;
    stat_a = '0;
    stat_a[5:0] = s.flags_a;
    stat_a[bdp_pkg::SA_RUN +: 2] = s.phase_on;
    stat_b = '0;
    stat_b[1:0] = s.flags_b;
    stat_b[bdp_pkg::SB_PIN +: 2] = s.pin_level;

    next_s = s;
    next_s.pin_s1 = enable_pin_in;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_s3 = s.pin_s2;
    if (s.pin_s2 == s.pin_s3) begin
      next_s.pin_level = s.pin_s3;
    end
    next_s.en_prev = en_bits;
    // Clear on read; a set in the same cycle wins.
    next_s.flags_a = (rd_a ? 6'h00 : s.flags_a) | ev_a;
    next_s.flags_b = (rd_b ? 2'h0 : s.flags_b) | ev_b;
    if (rd_a || rd_b) begin
      next_s.rdata = rd_a ? stat_a : stat_b;
    end else if (rd_in && addr_in == bdp_pkg::ADDR_CONTROL) begin
      next_s.rdata = s.control;
    end else if (rd_in && addr_in == bdp_pkg::ADDR_CONFIG) begin
      next_s.rdata = s.config_reg;
    end else if (rd_in) begin
      next_s.rdata = 16'h0000;
    end
    if (wr_in && addr_in == bdp_pkg::ADDR_CONTROL) begin
      next_s.control = wdata_in;
    end
    if (wr_in && addr_in == bdp_pkg::ADDR_CONFIG) begin
      next_s.config_reg = wdata_in;
    end
    if (s.blank != '0) begin
      next_s.blank = s.blank - 1'b1;
    end else begin
      next_s.blank_done = 1'b1;
    end
    if (sense_in.over_shutdown) begin
      next_s.tsd_active = 1'b1;
    end else if (!sense_in.over_warning) begin
      next_s.tsd_active = 1'b0;
    end
    if (sense_in.boost_overvoltage) begin
      next_s.ov_active = 1'b1;
    end else if (sense_in.boost_reactivated) begin
      next_s.ov_active = 1'b0;
    end
    unique case (s.mode)
      bdp_pkg::BDP_RESET: begin
        next_s.regulator_on = 1'b0;
        next_s.timer = '0;
        if (sense_in.supply_ok && any_pin) begin
          next_s.mode = bdp_pkg::BDP_INIT;
          next_s.regulator_on = 1'b1;
        end
      end
      bdp_pkg::BDP_INIT: begin
        next_s.timer = s.timer + 1'b1;
        if (s.timer >= bdp_pkg::TMR_W'(INIT_DELAY - 1)) begin
          next_s.mode = sense_in.otp_failsafe_lock ? bdp_pkg::BDP_FAILSAFE
            : bdp_pkg::BDP_NORMAL;
        end
      end
      bdp_pkg::BDP_NORMAL, bdp_pkg::BDP_FAILSAFE: begin
        if (!any_pin && !s.control[bdp_pkg::CT_KEEP]) begin
          next_s.mode = bdp_pkg::BDP_RESET;
          next_s.regulator_on = 1'b0;
        end
      end
    endcase
    // A shutdown arms recovery whatever the enable bit, so that dropping the bit cannot bypass the flag check.
    for (int i = 0; i < bdp_pkg::PHASES; i++) begin
      if (s.mode == bdp_pkg::BDP_RESET || s.mode == bdp_pkg::BDP_INIT) begin
        next_s.phase_on[i] = 1'b0;
        next_s.recover_armed[i] = 1'b0;
      end else if (s.tsd_active || sense_in.divider_undervoltage || uv_lock) begin
        next_s.phase_on[i] = 1'b0;
        next_s.recover_armed[i] = 1'b1;
      end else if (!en_bits[i] || (pin_mode && !s.pin_level[i])) begin
        next_s.phase_on[i] = 1'b0;
      end else if (s.ov_active) begin
        next_s.phase_on[i] = 1'b0;
      end else if (s.recover_armed[i]) begin
        if (auto_rec && !s.flags_b[bdp_pkg::SB_DUV]) begin
          next_s.phase_on[i] = 1'b1;
          next_s.recover_armed[i] = 1'b0;
        end else if (en_rise[i] && !s.flags_a[bdp_pkg::SA_TSD]) begin
          next_s.phase_on[i] = 1'b1;
          next_s.recover_armed[i] = 1'b0;
        end
      end else begin
        next_s.phase_on[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s <= '0;
      s.mode <= bdp_pkg::BDP_RESET;
      s.flags_a <= 6'h01 << bdp_pkg::SA_POR;
      s.blank <= bdp_pkg::TMR_W'(UV_BLANK);
      s.control <= bdp_pkg::CONTROL_RESET;
      s.config_reg <= bdp_pkg::CONFIG_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_out = s.rdata;
  assign gate_enable_out = s.phase_on;
  assign regulator_on_out = s.regulator_on;
  assign mode_out = s.mode;

  a_tsd_off: assert property (@(posedge clock_in) disable iff (rst_in)
    s.tsd_active |=> gate_enable_out == 2'h0) else $error("phase on during shutdown");
  a_tsd_hyst: assert property (@(posedge clock_in) disable iff (rst_in)
    (s.tsd_active && sense_in.over_warning) |=> s.tsd_active) else $error("shutdown ended early");
  a_flag_set: assert property (@(posedge clock_in) disable iff (rst_in)
    sense_in.serial_error |=> s.flags_a[bdp_pkg::SA_SERR]) else $error("serial flag lost");
  a_warn_set: assert property (@(posedge clock_in) disable iff (rst_in)
    sense_in.over_warning |=> s.flags_a[bdp_pkg::SA_TW]) else $error("warning flag lost");
  a_clear_read: assert property (@(posedge clock_in) disable iff (rst_in)
    (rd_b && !ev_b[bdp_pkg::SB_NOK]) |=> !s.flags_b[bdp_pkg::SB_NOK]) else $error("no clear");
  a_ov_off: assert property (@(posedge clock_in) disable iff (rst_in)
    s.ov_active |=> gate_enable_out == 2'h0) else $error("phase on in overvoltage");
  a_en_off: assert property (@(posedge clock_in) disable iff (rst_in)
    !en_bits[0] |=> !gate_enable_out[0]) else $error("phase on without enable");
  a_pin_gate: assert property (@(posedge clock_in) disable iff (rst_in)
    (pin_mode && !s.pin_level[1]) |=> !gate_enable_out[1]) else $error("pin mode ignored");
  a_reg_leave: assert property (@(posedge clock_in) disable iff (rst_in)
    (s.mode == bdp_pkg::BDP_NORMAL && !any_pin && !s.control[bdp_pkg::CT_KEEP])
    |=> s.mode == bdp_pkg::BDP_RESET && !regulator_on_out) else $error("no return to reset");
  a_init_wake: assert property (@(posedge clock_in) disable iff (rst_in)
    (s.mode == bdp_pkg::BDP_RESET && sense_in.supply_ok && any_pin)
    |=> s.mode == bdp_pkg::BDP_INIT && regulator_on_out) else $error("no wake");
  a_ov_flag: assert property (@(posedge clock_in) disable iff (rst_in)
    sense_in.boost_overvoltage |=> s.flags_a[bdp_pkg::SA_OV]) else $error("overvoltage flag lost");
  a_duv_off: assert property (@(posedge clock_in) disable iff (rst_in)
    sense_in.divider_undervoltage |=> gate_enable_out == 2'h0) else $error("phase on in divider fault");
  a_uv_lock: assert property (@(posedge clock_in) disable iff (rst_in)
    uv_lock |=> gate_enable_out == 2'h0) else $error("phase on in gate lockout");
  a_temp_flag: assert property (@(posedge clock_in) disable iff (rst_in)
    temp_hit |=> s.flags_a[bdp_pkg::SA_TEMP]) else $error("temperature flag lost");
  a_armed_hold: assert property (@(posedge clock_in) disable iff (rst_in)
    (s.recover_armed[0] && !auto_rec && !en_rise[0]) |=> !gate_enable_out[0]) else $error("recovery without edge");
endmodule
`default_nettype wire

// [tb/bdp_host.sv]
`timescale 1ns/1ps
`default_nettype none
module bdp_host (
  input wire logic clock_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [15:0] wdata_out
);
  initial begin
    addr_out = 8'hff;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 16'hffff;
  end
  // Released lines show the inverse so stale values never look valid.
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clock_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  // Status is read after each event except the failsafe shutdown; the thermal test sends one recovery edge before its read clears the flags.
  task automatic read_reg(input logic [7:0] a);
    @(posedge clock_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clock_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
  endtask
endmodule
`default_nettype wire

// [tb/test_booster_diag_protect_power_modes.sv]
`timescale 1ns/1ps
`default_nettype none
module test_booster_diag_protect_power_modes;
  localparam logic [7:0] SA = bdp_pkg::ADDR_STATUS_A;
  localparam logic [7:0] SB = bdp_pkg::ADDR_STATUS_B;
  localparam logic [7:0] CT = bdp_pkg::ADDR_CONTROL;
  localparam logic [7:0] CF = bdp_pkg::ADDR_CONFIG;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] pins = 2'b11;
  bdp_pkg::bdp_sense_t sense = 15'h0002;
  logic [7:0] addr;
  logic wr;
  logic rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [1:0] gate;
  logic reg_on;
  bdp_pkg::bdp_mode_t mode;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  logic [15:0] exp_q[$];
  logic rd_q = 1'b0;
  logic [31:0] seed = 32'hd6fb;
  always #5 clock_in = ~clock_in;
  bdp_host host_u (.clock_in(clock_in), .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
  bdp_core #(.UV_BLANK(20), .INIT_DELAY(10)) dut_u (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr),
    .wr_in(wr), .rd_in(rd), .wdata_in(wdata), .sense_in(sense), .enable_pin_in(pins), .rdata_out(rdata),
    .gate_enable_out(gate), .regulator_on_out(reg_on), .mode_out(mode));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wc(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host_u.read_reg(a);
  endtask
  task automatic wrx(input logic [7:0] a, input logic [15:0] d);
    host_u.write_reg(a, d);
  endtask
  task automatic toggle(input logic [15:0] c);
    wrx(CT, c & 16'hfffc);
    wrx(CT, c);
  endtask
  task automatic gchk(input logic [1:0] e);
    wc(4);
    chk("gate", {14'h0, gate}, {14'h0, e});
  endtask
  // Read data appears the cycle after the strobe and is matched to the oldest note.
  always @(posedge clock_in) begin
    if (rd_q) begin
      chk("rdata", rdata, exp_q[0]);
      void'(exp_q.pop_front());
    end
    rd_q <= rd;
  end
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    wc(4);
    rst_in <= 1'b0;
    for (int i = 0; i < 100 && mode !== bdp_pkg::BDP_NORMAL; i++) wc(1);
    chk("mode", {14'h0, mode}, 16'h0002);
    chk("regulator", {15'h0, reg_on}, 16'h0001);
    rdx(SA, 16'h0010);
    rdx(SA, 16'h0000);
    rdx(SB, 16'h0300);
    wrx(CT, 16'h0003);
    gchk(2'b11);
    rdx(SA, 16'h0300);
    sense.over_warning <= 1'b1;
    wc(2);
    sense.over_warning <= 1'b0;
    gchk(2'b11);
    rdx(SA, 16'h0301);
    $display("test startup and warning done");
    sense.over_shutdown <= 1'b1;
    sense.over_warning <= 1'b1;
    gchk(2'b00);
    sense.over_shutdown <= 1'b0;
    gchk(2'b00);
    sense.over_warning <= 1'b0;
    toggle(16'h0003);
    gchk(2'b00);
    rdx(SA, 16'h0003);
    toggle(16'h0003);
    gchk(2'b11);
    wrx(CT, 16'h0013);
    sense.over_shutdown <= 1'b1;
    gchk(2'b00);
    sense.over_shutdown <= 1'b0;
    gchk(2'b11);
    rdx(SA, 16'h0302);
    $display("test thermal done");
    sense.boost_overvoltage <= 1'b1;
    gchk(2'b00);
    sense.boost_overvoltage <= 1'b0;
    sense.boost_reactivated <= 1'b1;
    gchk(2'b11);
    rdx(SA, 16'h0320);
    sense.serial_error <= 1'b1;
    wc(1);
    sense.serial_error <= 1'b0;
    gchk(2'b11);
    rdx(SA, 16'h0308);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      wrx(CF, {13'h0, seed[2:0]});
      sense.temp_code <= seed[5:3];
      wc(2);
      sense.temp_code <= 3'h0;
      rdx(SA, {6'h0, 2'b11, 5'h0, seed[5:3] > seed[2:0], 2'b00});
    end
    $display("test overvoltage serial temperature done");
    wrx(CT, 16'h0003);
    sense.divider_undervoltage <= 1'b1;
    gchk(2'b00);
    sense.divider_undervoltage <= 1'b0;
    gchk(2'b00);
    rdx(SB, 16'h0301);
    toggle(16'h0003);
    gchk(2'b11);
    sense.gate_supply_bad <= 1'b1;
    wc(2);
    sense.gate_supply_bad <= 1'b0;
    gchk(2'b11);
    rdx(SB, 16'h0302);
    wrx(CF, 16'h0040);
    sense.gate_supply_level <= 3'h2;
    gchk(2'b00);
    sense.gate_supply_level <= 3'h7;
    gchk(2'b00);
    rdx(SB, 16'h0300);
    toggle(16'h0003);
    gchk(2'b11);
    $display("test supply protections done");
    wrx(CT, 16'h0023);
    pins <= 2'b01;
    wc(4);
    gchk(2'b01);
    wrx(CT, 16'h0040);
    pins <= 2'b00;
    wc(8);
    chk("mode", {14'h0, mode}, 16'h0002);
    wrx(CT, 16'h0000);
    wc(4);
    chk("mode", {14'h0, mode}, 16'h0000);
    chk("regulator", {15'h0, reg_on}, 16'h0000);
    $display("test pin mode and keep done");
    sense.otp_failsafe_lock <= 1'b1;
    pins <= 2'b11;
    wc(30);
    chk("mode", {14'h0, mode}, 16'h0003);
    wrx(CT, 16'h0003);
    sense.over_shutdown <= 1'b1;
    gchk(2'b00);
    sense.over_shutdown <= 1'b0;
    gchk(2'b11);
    rdx(CT, 16'h0003);
    $display("test failsafe recovery done");
    wc(3);
    conclude();
  end
endmodule
`default_nettype wire
